/* File: hw/tmr_regs.vh */
// Contract
// - temperature results are signed two's complement, 0.125 degC per LSB
// - local result at pointer 00h resets 0000h, data in 15:4, 3:0 zero
// - remote one result at 01h is read-only, resets zero, left aligned
// - remote two result at 02h is read-only, resets zero, left aligned
// - SPI config at 0Ah: enables at bits 5,4,3, correction bit 2, reset 003Ch
// - I2C config uses bits 13:10, low byte reads ones, reset 3CFFh
// - each sensor enable bit turns its channel on when one; resets one
// - correction bit turns series-resistance correction on; resets one
// - SPI rate register at 0Bh holds rate select in 2:0, reset 0007h
// - I2C rate select sits in 10:8, low byte ones, reset 07FFh
// - rate code 000 gives 128x minimum time, each step halves it
// - local sensor alone gives a 15 ms monitoring cycle
// - one remote alone gives 44 ms, or 93 ms with correction
// - one remote plus local gives 59 ms, or 108 ms with correction
// - both remotes without local give 88 ms, or 186 ms with correction
// - all three sensors give 103 ms, or 201 ms with correction
// - ideality registers 21h and 22h serve remote one and remote two
// - SPI ideality value sits in 7:0, upper byte zero, reset 0000h
// - I2C ideality value sits in 15:8, low byte ones, reset 00FFh
// - an 8-bit pointer loaded by the host selects registers; accesses keep it
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// register pointers
`define TMR_PTR_LOCAL_RESULT 8'h00
`define TMR_PTR_REMOTE1_RESULT 8'h01
`define TMR_PTR_REMOTE2_RESULT 8'h02
`define TMR_PTR_SENSOR_CONFIG 8'h0A
`define TMR_PTR_CONV_RATE 8'h0B
`define TMR_PTR_REMOTE1_IDEAL 8'h21
`define TMR_PTR_REMOTE2_IDEAL 8'h22

// reset values
`define TMR_RST_RESULT 16'h0000
`define TMR_RST_CFG_SPI 16'h003C
`define TMR_RST_CFG_I2C 16'h3CFF
`define TMR_RST_RATE_SPI 16'h0007
`define TMR_RST_RATE_I2C 16'h07FF
`define TMR_RST_IDEAL_SPI 16'h0000
`define TMR_RST_IDEAL_I2C 16'h00FF
`define TMR_RST_ENABLE 1'h1
`define TMR_RST_RATE 3'h7
`define TMR_RST_IDEAL 8'h00

// field positions, low bit of each field
`define TMR_RES_LSB 4
`define TMR_CFG_SPI_LSB 2
`define TMR_CFG_I2C_LSB 10
`define TMR_RATE_SPI_LSB 0
`define TMR_RATE_I2C_LSB 8
`define TMR_IDEAL_SPI_LSB 0
`define TMR_IDEAL_I2C_LSB 8
`define TMR_I2C_LOW_FILL 8'hFF

// monitoring cycle times in ms at the fastest rate, code 7
`define TMR_T_LOCAL_MS 15
`define TMR_T_REM_MS 44
`define TMR_T_REM_RC_MS 93
`define TMR_T_LREM_MS 59
`define TMR_T_LREM_RC_MS 108
`define TMR_T_RR_MS 88
`define TMR_T_RR_RC_MS 186
`define TMR_T_ALL_MS 103
`define TMR_T_ALL_RC_MS 201

// clock rate and derived cycle counts
`define TMR_CLK_KHZ 40000
`define TMR_CYC_LOCAL (`TMR_T_LOCAL_MS * `TMR_CLK_KHZ)
`define TMR_CYC_REM (`TMR_T_REM_MS * `TMR_CLK_KHZ)
`define TMR_CYC_REM_RC (`TMR_T_REM_RC_MS * `TMR_CLK_KHZ)
`define TMR_CYC_LREM (`TMR_T_LREM_MS * `TMR_CLK_KHZ)
`define TMR_CYC_LREM_RC (`TMR_T_LREM_RC_MS * `TMR_CLK_KHZ)
`define TMR_CYC_RR (`TMR_T_RR_MS * `TMR_CLK_KHZ)
`define TMR_CYC_RR_RC (`TMR_T_RR_RC_MS * `TMR_CLK_KHZ)
`define TMR_CYC_ALL (`TMR_T_ALL_MS * `TMR_CLK_KHZ)
`define TMR_CYC_ALL_RC (`TMR_T_ALL_RC_MS * `TMR_CLK_KHZ)

`endif

/* File: hw/tmr_cycle_timer.v */
`timescale 1ns/1ps
`include "tmr_regs.vh"

module tmr_cycle_timer #(
    parameter CW = 32
) (
    // clock and control
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire restart,
    // cycle length
    input wire [CW-1:0] base_cycles,
    input wire [2:0] scale_sel,
    // status
    output reg tick,
    output reg running
);

    reg [CW-1:0] cnt_reg;
    wire [2:0] shift_amt;
    wire [CW-1:0] period;

    assign shift_amt = 3'h7 - scale_sel;
    assign period = base_cycles << shift_amt;

    // down counter, one tick pulse at the end of every cycle
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= {CW{1'b0}};
            tick <= 1'b0;
            running <= 1'b0;
        end
        else if (ce)
        begin
            tick <= 1'b0;
            if (base_cycles == {CW{1'b0}})
            begin
                running <= 1'b0; // no sensor active, stay idle
            end
            else if (restart || !running)
            begin
                cnt_reg <= period - {{(CW-1){1'b0}}, 1'b1};
                running <= 1'b1;
            end
            else if (cnt_reg == {CW{1'b0}})
            begin
                tick <= 1'b1;
                cnt_reg <= period - {{(CW-1){1'b0}}, 1'b1};
            end
            else
            begin
                cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

/* File: hw/tmr_top.v */
`timescale 1ns/1ps
`include "tmr_regs.vh"

module tmr_top #(
    parameter [31:0] CYC_LOCAL = `TMR_CYC_LOCAL,
    parameter [31:0] CYC_REM = `TMR_CYC_REM,
    parameter [31:0] CYC_REM_RC = `TMR_CYC_REM_RC,
    parameter [31:0] CYC_LREM = `TMR_CYC_LREM,
    parameter [31:0] CYC_LREM_RC = `TMR_CYC_LREM_RC,
    parameter [31:0] CYC_RR = `TMR_CYC_RR,
    parameter [31:0] CYC_RR_RC = `TMR_CYC_RR_RC,
    parameter [31:0] CYC_ALL = `TMR_CYC_ALL,
    parameter [31:0] CYC_ALL_RC = `TMR_CYC_ALL_RC
) (
    // clock, reset, enable
    input wire clk_sys,
    input wire rstn,
    input wire ce,
    // interface variant, high selects the I2C layouts
    input wire i2c_mode,
    // register pointer and access strobes
    input wire ptr_load,
    input wire [7:0] ptr_in,
    input wire wr_strobe,
    input wire [15:0] wr_data,
    input wire rd_strobe,
    output reg [15:0] rd_data,
    output reg rd_valid,
    // raw conversion samples, signed 0.125 degC per LSB
    input wire [11:0] local_sensor_sample,
    input wire [11:0] remote_sensor_one_sample,
    input wire [11:0] remote_sensor_two_sample,
    // controls to the measurement front end
    output wire local_sense_enable,
    output wire remote1_enable,
    output wire remote2_enable,
    output wire series_resistance_correct,
    output wire rate_select_bit2,
    output wire rate_select_bit1,
    output wire rate_select_bit0,
    output wire [7:0] ideality_adjust_one,
    output wire [7:0] ideality_adjust_two,
    // monitoring cycle status
    output reg cycle_done,
    output wire cycle_active
);

    // synchronised reset
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    // register pointer
    reg [7:0] ptr_reg;

    // result registers, 12 significant bits each
    reg [11:0] local_result_reg;
    reg [11:0] remote1_result_reg;
    reg [11:0] remote2_result_reg;

    // configuration fields
    reg local_en_reg;
    reg remote1_en_reg;
    reg remote2_en_reg;
    reg rc_en_reg;
    reg [2:0] rate_reg;
    reg [7:0] ideal1_reg;
    reg [7:0] ideal2_reg;

    // cycle control
    reg restart_reg;
    reg [31:0] base_next;
    wire timer_tick;
    wire timer_running;

    // write decode
    wire wr_cfg;
    wire wr_rate;
    wire wr_ideal1;
    wire wr_ideal2;
    wire [3:0] cfg_field;
    wire [2:0] rate_field;
    wire [7:0] ideal_field;

    // read path
    reg [15:0] rd_next;

    // release the asynchronous reset through two flops
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // pointer held
    // the pointer only moves when the host loads it, never on an access
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_reg <= 8'h00;
        end
        else if (ce && ptr_load)
        begin
            ptr_reg <= ptr_in;
        end
    end

    // decode writable only
    // result pointers and unmapped pointers have no write decode
    assign wr_cfg = wr_strobe && (ptr_reg == `TMR_PTR_SENSOR_CONFIG);
    assign wr_rate = wr_strobe && (ptr_reg == `TMR_PTR_CONV_RATE);
    assign wr_ideal1 = wr_strobe && (ptr_reg == `TMR_PTR_REMOTE1_IDEAL);
    assign wr_ideal2 = wr_strobe && (ptr_reg == `TMR_PTR_REMOTE2_IDEAL);

    assign cfg_field = i2c_mode ?
        wr_data[`TMR_CFG_I2C_LSB +: 4] : wr_data[`TMR_CFG_SPI_LSB +: 4];

    assign rate_field = i2c_mode ?
        wr_data[`TMR_RATE_I2C_LSB +: 3] : wr_data[`TMR_RATE_SPI_LSB +: 3];

    assign ideal_field = i2c_mode ?
        wr_data[`TMR_IDEAL_I2C_LSB +: 8] : wr_data[`TMR_IDEAL_SPI_LSB +: 8];

    // correction reset one
    // sensor configuration, only the four field bits are stored
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            remote2_en_reg <= `TMR_RST_ENABLE;
            remote1_en_reg <= `TMR_RST_ENABLE;
            local_en_reg <= `TMR_RST_ENABLE;
            rc_en_reg <= `TMR_RST_ENABLE;
        end
        else if (ce && wr_cfg)
        begin
            remote2_en_reg <= cfg_field[3];
            remote1_en_reg <= cfg_field[2];
            local_en_reg <= cfg_field[1];
            rc_en_reg <= cfg_field[0];
        end
    end

    // conversion rate select
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_reg <= `TMR_RST_RATE;
        end
        else if (ce && wr_rate)
        begin
            rate_reg <= rate_field;
        end
    end

    // per-channel ideality
    // the unused byte of the word is dropped on write
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ideal1_reg <= `TMR_RST_IDEAL;
            ideal2_reg <= `TMR_RST_IDEAL;
        end
        else if (ce)
        begin
            if (wr_ideal1)
            begin
                ideal1_reg <= ideal_field;
            end
            if (wr_ideal2)
            begin
                ideal2_reg <= ideal_field;
            end
        end
    end

    // start a fresh cycle once the new settings are in place
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            restart_reg <= 1'b0;
        end
        else if (ce)
        begin
            restart_reg <= wr_cfg || wr_rate;
        end
    end

    // cycle length at the fastest rate, code 7, for the active sensor mix
    always @*
    begin
        base_next = 32'h00000000;
        case ({local_en_reg, remote1_en_reg, remote2_en_reg})
            3'b100:
            begin
                base_next = CYC_LOCAL;
            end
            3'b010, 3'b001:
            begin
                base_next = rc_en_reg ? CYC_REM_RC : CYC_REM;
            end
            3'b110, 3'b101:
            begin
                base_next = rc_en_reg ? CYC_LREM_RC : CYC_LREM;
            end
            3'b011:
            begin
                base_next = rc_en_reg ? CYC_RR_RC : CYC_RR;
            end
            3'b111:
            begin
                base_next = rc_en_reg ? CYC_ALL_RC : CYC_ALL;
            end
            default:
            begin
                base_next = 32'h00000000; // nothing to monitor
            end
        endcase
    end

    tmr_cycle_timer #(
        .CW(32)
    ) u_timer (
        .clk(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .restart(restart_reg),
        .base_cycles(base_next),
        .scale_sel(rate_reg),
        .tick(timer_tick),
        .running(timer_running)
    );

    // signed sample stored
    // disabled channels keep their last reading
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            local_result_reg <= 12'h000;
            remote1_result_reg <= 12'h000;
            remote2_result_reg <= 12'h000;
            cycle_done <= 1'b0;
        end
        else if (ce)
        begin
            cycle_done <= timer_tick;
            if (timer_tick && local_en_reg)
            begin
                local_result_reg <= local_sensor_sample;
            end
            if (timer_tick && remote1_en_reg)
            begin
                remote1_result_reg <= remote_sensor_one_sample;
            end
            if (timer_tick && remote2_en_reg)
            begin
                remote2_result_reg <= remote_sensor_two_sample;
            end
        end
    end

    // read multiplexer, layout follows the interface variant
    always @*
    begin
        rd_next = 16'h0000;
        case (ptr_reg)
            `TMR_PTR_LOCAL_RESULT:
            begin
                rd_next = {local_result_reg, 4'h0};
            end
            `TMR_PTR_REMOTE1_RESULT:
            begin
                rd_next = {remote1_result_reg, 4'h0};
            end
            `TMR_PTR_REMOTE2_RESULT:
            begin
                rd_next = {remote2_result_reg, 4'h0};
            end
            `TMR_PTR_SENSOR_CONFIG:
            begin
                if (i2c_mode)
                begin
                    rd_next = {2'h0, remote2_en_reg, remote1_en_reg, local_en_reg,
                        rc_en_reg, 2'h0, `TMR_I2C_LOW_FILL};
                end
                else
                begin
                    rd_next = {10'h000, remote2_en_reg, remote1_en_reg,
                        local_en_reg, rc_en_reg, 2'h0};
                end
            end
            `TMR_PTR_CONV_RATE:
            begin
                if (i2c_mode)
                begin
                    rd_next = {5'h00, rate_reg, `TMR_I2C_LOW_FILL};
                end
                else
                begin
                    rd_next = {13'h0000, rate_reg};
                end
            end
            `TMR_PTR_REMOTE1_IDEAL:
            begin
                if (i2c_mode)
                begin
                    rd_next = {ideal1_reg, `TMR_I2C_LOW_FILL};
                end
                else
                begin
                    rd_next = {8'h00, ideal1_reg};
                end
            end
            `TMR_PTR_REMOTE2_IDEAL:
            begin
                if (i2c_mode)
                begin
                    rd_next = {ideal2_reg, `TMR_I2C_LOW_FILL};
                end
                else
                begin
                    rd_next = {8'h00, ideal2_reg};
                end
            end
            default:
            begin
                rd_next = 16'h0000; // unmapped pointer
            end
        endcase
    end

    // registered read data, held until the next read strobe
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            rd_valid <= rd_strobe;
            if (rd_strobe)
            begin
                rd_data <= rd_next;
            end
        end
    end

    // front end controls come straight from the configuration flops
    assign local_sense_enable = local_en_reg;
    assign remote1_enable = remote1_en_reg;
    assign remote2_enable = remote2_en_reg;
    assign series_resistance_correct = rc_en_reg;
    assign rate_select_bit2 = rate_reg[2];
    assign rate_select_bit1 = rate_reg[1];
    assign rate_select_bit0 = rate_reg[0];

    // signed ideality out
    // zero is passed through unchanged, meaning default ideality
    assign ideality_adjust_one = ideal1_reg;
    assign ideality_adjust_two = ideal2_reg;

    assign cycle_active = timer_running;

endmodule

/* File: tb/tmr_chk.sv */
`timescale 1ns/1ps
module tmr_chk (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    input wire ce,
    input wire i2c_mode,
    // register port
    input wire ptr_load,
    input wire [7:0] ptr_in,
    input wire wr_strobe,
    input wire [15:0] wr_data,
    input wire rd_strobe,
    input wire [15:0] rd_data,
    input wire rd_valid,
    // front end controls and status
    input wire local_sense_enable,
    input wire remote1_enable,
    input wire remote2_enable,
    input wire series_resistance_correct,
    input wire rate_select_bit2,
    input wire rate_select_bit1,
    input wire rate_select_bit0,
    input wire [7:0] ideality_adjust_one,
    input wire [7:0] ideality_adjust_two,
    input wire cycle_done,
    input wire cycle_active
);
    reg [7:0] ptr_q;
    reg [7:0] rd_ptr;
    // enables as {remote2, remote1, local, correction}, and the written field for either layout
    wire [3:0] en4 = {remote2_enable, remote1_enable, local_sense_enable, series_resistance_correct};
    wire [2:0] rate = {rate_select_bit2, rate_select_bit1, rate_select_bit0};
    wire [3:0] wr_cfg = i2c_mode ? wr_data[13:10] : wr_data[5:2];

    // shadow of the host pointer and of the pointer a read used
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_q <= 8'h00;
            rd_ptr <= 8'hFF;
        end
        else if (ce)
        begin
            if (ptr_load)
                ptr_q <= ptr_in;
            if (rd_strobe)
                rd_ptr <= ptr_q;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    property p_rd_answer;
        rd_strobe && ce |=> rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_res_low;
        rd_valid && rd_ptr < 8'h03 |-> rd_data[3:0] == 4'h0;
    endproperty
    a_res_low: assert property (p_res_low) else $error("result low nibble set");
    property p_cfg_read;
        rd_valid && rd_ptr == 8'h0A |->
            rd_data == (i2c_mode ? {2'b00, en4, 2'b00, 8'hFF} : {10'h000, en4, 2'b00});
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
    property p_rate_read;
        rd_valid && rd_ptr == 8'h0B |->
            rd_data == (i2c_mode ? {5'h00, rate, 8'hFF} : {13'h0000, rate});
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("rate readback wrong");
    property p_ideal_read;
        rd_valid && rd_ptr == 8'h21 |->
            rd_data == (i2c_mode ? {ideality_adjust_one, 8'hFF} : {8'h00, ideality_adjust_one});
    endproperty
    a_ideal_read: assert property (p_ideal_read) else $error("ideality readback wrong");
    property p_cfg_write;
        wr_strobe && ce && ptr_q == 8'h0A |=> en4 == $past(wr_cfg);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
    property p_done_pulse;
        cycle_done && ce |=> !cycle_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("cycle_done too long");
    property p_idle;
        (en4[3:1] == 3'b000) [*3] |-> !cycle_active && !cycle_done;
    endproperty
    a_idle: assert property (p_idle) else $error("timer runs with no sensor");
    property p_rst_vals;
        $rose(rstn) |-> en4 == 4'hF && rate == 3'h7 && ideality_adjust_two == 8'h00;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
endmodule

bind tmr_top tmr_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .i2c_mode(i2c_mode),
    .ptr_load(ptr_load), .ptr_in(ptr_in), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
    .local_sense_enable(local_sense_enable), .remote1_enable(remote1_enable),
    .remote2_enable(remote2_enable), .series_resistance_correct(series_resistance_correct),
    .rate_select_bit2(rate_select_bit2), .rate_select_bit1(rate_select_bit1),
    .rate_select_bit0(rate_select_bit0), .ideality_adjust_one(ideality_adjust_one),
    .ideality_adjust_two(ideality_adjust_two), .cycle_done(cycle_done),
    .cycle_active(cycle_active));

/* File: tb/tmr_host.sv */
`timescale 1ns/1ps
module tmr_host (
    // clock
    input wire clk_sys,
    // register port towards the device
    output reg ptr_load,
    output reg [7:0] ptr_in,
    output reg wr_strobe,
    output reg [15:0] wr_data,
    output reg rd_strobe,
    input wire [15:0] rd_data,
    input wire rd_valid
);
    // idle port at time zero
    initial
    begin
        ptr_load = 1'b0;
        ptr_in = 8'h00;
        wr_strobe = 1'b0;
        wr_data = 16'h0000;
        rd_strobe = 1'b0;
    end

    // one access; released data lines are inverted so stale values never match
    task access(input ld, input we, input [7:0] a, input [15:0] d, input [3:0] gap,
        output [15:0] q);
        begin
            q = 16'hXXXX;
            if (ld)
            begin
                @(negedge clk_sys);
                ptr_load = 1'b1;
                ptr_in = a;
            end
            @(negedge clk_sys);
            ptr_load = 1'b0;
            ptr_in = ~ptr_in;
            wr_strobe = we;
            wr_data = d;
            rd_strobe = !we;
            @(negedge clk_sys);
            wr_strobe = 1'b0;
            rd_strobe = 1'b0;
            wr_data = ~d;
            if (!we && rd_valid === 1'b1)
                q = rd_data;
            repeat (gap + 1) @(negedge clk_sys);
        end
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg i2c_mode = 1'b0;
    reg ce = 1'b1;
    reg [11:0] s_lt = 12'h000;
    reg [11:0] s_r1 = 12'h000;
    reg [11:0] s_r2 = 12'h000;
    reg [15:0] q;
    integer n_fail = 0;
    integer compares = 0;
    wire ptr_load, wr_strobe, rd_strobe, rd_valid, cycle_done, cycle_active;
    wire loc_en, r1_en, r2_en, rc_en, rb2, rb1, rb0;
    wire [7:0] ptr_in, id1, id2;
    wire [15:0] wr_data, rd_data;
    // {enables r2 r1 local rc, base cycles} per sensor mix
    localparam [71:0] MIXES = 72'h34_45_96_67_B8_C9_DA_EB_FC;

    always #12.5 clk_sys = ~clk_sys;

    // device with the short cycle counts of the mix table, host model on its register port
    tmr_top #(.CYC_LOCAL({28'h0, MIXES[67:64]}), .CYC_REM({28'h0, MIXES[59:56]}),
        .CYC_REM_RC({28'h0, MIXES[51:48]}), .CYC_LREM({28'h0, MIXES[43:40]}),
        .CYC_LREM_RC({28'h0, MIXES[35:32]}), .CYC_RR({28'h0, MIXES[27:24]}),
        .CYC_RR_RC({28'h0, MIXES[19:16]}), .CYC_ALL({28'h0, MIXES[11:8]}),
        .CYC_ALL_RC({28'h0, MIXES[3:0]})) dut (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .i2c_mode(i2c_mode), .ptr_load(ptr_load),
        .ptr_in(ptr_in), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .rd_valid(rd_valid), .local_sensor_sample(s_lt),
        .remote_sensor_one_sample(s_r1), .remote_sensor_two_sample(s_r2),
        .local_sense_enable(loc_en), .remote1_enable(r1_en), .remote2_enable(r2_en),
        .series_resistance_correct(rc_en), .rate_select_bit2(rb2), .rate_select_bit1(rb1),
        .rate_select_bit0(rb0), .ideality_adjust_one(id1), .ideality_adjust_two(id2),
        .cycle_done(cycle_done), .cycle_active(cycle_active));
    tmr_host host (.clk_sys(clk_sys), .ptr_load(ptr_load), .ptr_in(ptr_in),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .rd_valid(rd_valid));

    task report_and_stop;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input string w, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("mismatch %s expected %h seen %h", w, e, g);
            end
        end
    endtask
    task rw(input [7:0] a, input [15:0] d);
        host.access(1'b1, 1'b1, a, d, 4'h0, q);
    endtask
    task rd_chk(input string w, input [7:0] a, input [15:0] e);
        begin
            host.access(1'b1, 1'b0, a, 16'h0000, 4'h1, q);
            chk(w, e, q);
        end
    endtask
    // skip pulses from before a restart, then wait for the next cycle end
    task wait_done;
        integer i;
        begin
            repeat (3) @(negedge clk_sys);
            i = 0;
            while (cycle_done !== 1'b1 && i < 3000)
            begin
                @(negedge clk_sys);
                i = i + 1;
            end
            if (i == 3000)
            begin
                n_fail = n_fail + 1;
                $display("mismatch cycle_done expected 1 seen timeout");
                report_and_stop;
            end
        end
    endtask

    task s_reset;
        begin
            rd_chk("local result", 8'h00, 16'h0000);
            rd_chk("remote1 result", 8'h01, 16'h0000);
            rd_chk("remote2 result", 8'h02, 16'h0000);
            rd_chk("config", 8'h0A, 16'h003C);
            rd_chk("rate", 8'h0B, 16'h0007);
            rd_chk("ideality one", 8'h21, 16'h0000);
            i2c_mode = 1'b1;
            rd_chk("config i2c", 8'h0A, 16'h3CFF);
            rd_chk("rate i2c", 8'h0B, 16'h07FF);
            rd_chk("ideality two i2c", 8'h22, 16'h00FF);
            i2c_mode = 1'b0;
        end
    endtask
    task s_access;
        begin
            rw(8'h01, 16'hFFF0);
            rd_chk("remote1 after write", 8'h01, 16'h0000);
            rw(8'h30, 16'hFFFF);
            rd_chk("unmapped", 8'h30, 16'h0000);
            rw(8'h0A, 16'hFFC3);
            rd_chk("config fixed bits", 8'h0A, 16'h0000);
            chk("cycle active", 0, cycle_active);
            rw(8'h0A, 16'h0018);
            // with the clock enable low neither pointer load nor write may land
            ce = 1'b0;
            rw(8'h0B, 16'h0000);
            ce = 1'b1;
            chk("rate frozen", 3'h7, {rb2, rb1, rb0});
            host.access(1'b0, 1'b0, 8'h00, 16'h0000, 4'h2, q);
            chk("config kept pointer", 16'h0018, q);
            chk("enables spi", 4'b0110, {r2_en, r1_en, loc_en, rc_en});
            i2c_mode = 1'b1;
            rw(8'h0A, 16'h2400);
            rd_chk("config i2c", 8'h0A, 16'h24FF);
            chk("enables i2c", 4'b1001, {r2_en, r1_en, loc_en, rc_en});
            i2c_mode = 1'b0;
        end
    endtask
    task s_rate;
        integer c;
        reg [2:0] r;
        begin
            for (c = 0; c < 8; c = c + 1)
            begin
                r = c[2:0];
                i2c_mode = r[0];
                rw(8'h0B, r[0] ? {5'h1F, r, 8'h00} : {13'h1FFF, r});
                rd_chk("rate", 8'h0B, r[0] ? {5'h00, r, 8'hFF} : {13'h0000, r});
                chk("rate pins", r, {rb2, rb1, rb0});
            end
            i2c_mode = 1'b0;
        end
    endtask
    task s_ideal;
        begin
            rw(8'h21, 16'h12A5);
            rd_chk("ideality one", 8'h21, 16'h00A5);
            chk("ideality one pins", 8'hA5, id1);
            i2c_mode = 1'b1;
            rw(8'h22, 16'h8000);
            rd_chk("ideality two i2c", 8'h22, 16'h80FF);
            chk("ideality two pins", 8'h80, id2);
            i2c_mode = 1'b0;
            rd_chk("ideality two spi", 8'h22, 16'h0080);
        end
    endtask
    task s_results;
        begin
            s_lt = 12'hF38;
            s_r1 = 12'h7FF;
            s_r2 = 12'h190;
            rw(8'h0A, 16'h003C);
            wait_done;
            rd_chk("local result", 8'h00, 16'hF380);
            rd_chk("remote1 result", 8'h01, 16'h7FF0);
            rd_chk("remote2 result", 8'h02, 16'h1900);
            rw(8'h0A, 16'h0034);
            s_lt = 12'h800;
            s_r2 = 12'h001;
            wait_done;
            rd_chk("local result held", 8'h00, 16'hF380);
            rd_chk("remote2 result new", 8'h02, 16'h0010);
        end
    endtask
    // every sensor mix at the fastest rate, then the full mix at rates 6 and 0
    task s_period;
        integer k;
        integer n;
        reg [7:0] e;
        reg [2:0] r;
        begin
            for (k = 0; k < 11; k = k + 1)
            begin
                e = MIXES[71 - 8 * (k < 9 ? k : 8) -: 8];
                r = (k == 9) ? 3'h6 : (k == 10) ? 3'h0 : 3'h7;
                rw(8'h0B, {13'h0000, r});
                rw(8'h0A, {10'h000, e[7:4], 2'b00});
                wait_done;
                n = 1;
                @(negedge clk_sys);
                while (cycle_done !== 1'b1 && n < 3000)
                begin
                    @(negedge clk_sys);
                    n = n + 1;
                end
                chk("cycle period", {28'h0, e[3:0]} << (7 - r), n);
            end
        end
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        s_reset;
        s_access;
        s_rate;
        s_ideal;
        s_results;
        s_period;
        report_and_stop;
    end
endmodule
